// >>> obc_consts.vh
// Constants for the option byte clock and reset configuration block.
// Assumes the including file switches implicit nets off around its own code.
`ifndef OBC_CONSTS_VH
`define OBC_CONSTS_VH

// ----------------------------------------------------------------------------
// Option byte field positions
// ----------------------------------------------------------------------------
`define OBC_PKG_BIT        7
`define OBC_RSTDLY_BIT     6
`define OBC_TYPE_HI        5
`define OBC_TYPE_LO        4
`define OBC_RANGE_HI       3
`define OBC_RANGE_LO       1
`define OBC_PLLOFF_BIT     0
`define OBC_ERASED_BYTE    8'hFF

// ----------------------------------------------------------------------------
// Clock source types and frequency range codes
// ----------------------------------------------------------------------------
`define OBC_SRC_RESONATOR  2'h0
`define OBC_SRC_EXT_RC     2'h1
`define OBC_SRC_INT_RC     2'h2
`define OBC_SRC_EXT_CLK    2'h3
`define OBC_RANGE_1_2      3'h0
`define OBC_RANGE_2_4      3'h1
`define OBC_RANGE_4_8      3'h2
`define OBC_RANGE_8_16     3'h3

// ----------------------------------------------------------------------------
// Delay lengths in CPU cycles
// ----------------------------------------------------------------------------
`define OBC_DLY_LONG_CYC   4096
`define OBC_DLY_SHORT_CYC  256

// ----------------------------------------------------------------------------
// Register byte addresses and reset values
// ----------------------------------------------------------------------------
`define OBC_ADDR_CTRL      4'h0
`define OBC_ADDR_STATUS    4'h4
`define OBC_ADDR_CONFIG    4'h8
`define OBC_ADDR_PAD_DIR   4'hC
`define OBC_ADDR_PAD_PU    5'h10
`define OBC_PAD_DIR_RST    32'h00000000
`define OBC_RESP_OKAY      2'h0
`define OBC_RESP_SLVERR    2'h2

`endif

// >>> obc_option_config.v
// Option byte decoder with reset delay, halt exit delay and pad defaults.
// Assumes the option byte arrives from the non-volatile array on plain inputs
// and that aclk is the CPU clock; software sees decoded state over AXI4-Lite.
// Functional notes
// RQ1: Package bit set selects the large-pin variant, cleared selects the small-pin variant.
// RQ2: Each port has eight pads, and pads without a pin leave reset as pulled-up inputs.
// RQ3: Software should keep unbonded pads in their reset state to avoid extra current.
// RQ4: Delay bit cleared gives 4096 cycles, set gives 256, both at reset and at halt exit.
// RQ5: With a crystal or ceramic resonator the configurer should pick the 4096-cycle delay.
// RQ6: With clock security enabled the delay counter starts at once on the backup oscillator.
// RQ7: The two-bit type field picks resonator, external RC, internal RC or external clock.
// RQ8: With a resonator the range field sets the oscillator current for its frequency band.
// RQ9: With any other source the range field gives the normal operating frequency band.
// RQ10: Multiplier bit cleared enables the times-two multiplier, set bypasses it.
// RQ11: The configurer must not enable the multiplier with the internal RC oscillator.
// RQ12: The configurer may enable the multiplier only with the 2 to 4 MHz band.
// RQ13: The option byte has no bus address, is read only in programming mode, and reads FFh unprogrammed.
// RQ14: Decoded fields are caught during reset and held constant while running.
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`include "obc_consts.vh"
`default_nettype none

module obc_option_config #(
    parameter integer NUM_PORTS      = 4,
    parameter integer LONG_DLY_CYC   = `OBC_DLY_LONG_CYC,
    parameter integer SHORT_DLY_CYC  = `OBC_DLY_SHORT_CYC,
    parameter [31:0]  BONDED_LARGE   = 32'hFFFFFFFF,
    parameter [31:0]  BONDED_SMALL   = 32'h00FFFFFF
) (
    // Clock and reset.
    input  wire                     aclk,
    input  wire                     aresetn,
    // Option byte from the non-volatile array.
    input  wire [7:0]               opt_byte_nv,
    input  wire                     opt_byte_erased,
    input  wire                     clock_security_function_n,
    input  wire                     main_osc_ready,
    // Programming mode read port.
    input  wire                     prog_mode,
    input  wire                     prog_rd,
    output reg  [7:0]               prog_rdata_ff,
    output reg                      prog_rvalid_ff,
    // Halt wake-up event.
    input  wire                     wake_event,
    // Decoded configuration.
    output reg                      package_select_bit_ff,
    output reg  [1:0]               clock_source_type_ff,
    output reg  [3:0]               source_onehot_ff,
    output reg  [2:0]               osc_current_sel_ff,
    output reg  [2:0]               op_freq_range_ff,
    output reg                      pll_x2_en_ff,
    output reg                      reset_delay_select_ff,
    // CPU reset and hold.
    output reg                      cpu_reset_n_ff,
    output reg                      cpu_hold_ff,
    // Pad configuration.
    output reg  [NUM_PORTS*8-1:0]   pad_dir_ff,
    output reg  [NUM_PORTS*8-1:0]   pad_pullup_ff,
    // AXI4-Lite write address.
    input  wire [4:0]               s_axi_awaddr,
    input  wire                     s_axi_awvalid,
    output reg                      s_axi_awready_ff,
    // AXI4-Lite write data.
    input  wire [31:0]              s_axi_wdata,
    input  wire [3:0]               s_axi_wstrb,
    input  wire                     s_axi_wvalid,
    output reg                      s_axi_wready_ff,
    // AXI4-Lite write response.
    output reg  [1:0]               s_axi_bresp_ff,
    output reg                      s_axi_bvalid_ff,
    input  wire                     s_axi_bready,
    // AXI4-Lite read address.
    input  wire [4:0]               s_axi_araddr,
    input  wire                     s_axi_arvalid,
    output reg                      s_axi_arready_ff,
    // AXI4-Lite read data.
    output reg  [31:0]              s_axi_rdata_ff,
    output reg  [1:0]               s_axi_rresp_ff,
    output reg                      s_axi_rvalid_ff,
    input  wire                     s_axi_rready
);

    localparam integer PADS = NUM_PORTS * 8;

    // ------------------------------------------------------------------------
    // Option byte source
    // ------------------------------------------------------------------------

    // An erased array reads as all ones.
    wire [7:0] eff_byte = opt_byte_erased ? `OBC_ERASED_BYTE : opt_byte_nv; // RQ13

    wire [1:0] byte_type  = eff_byte[`OBC_TYPE_HI:`OBC_TYPE_LO];
    wire [2:0] byte_range = eff_byte[`OBC_RANGE_HI:`OBC_RANGE_LO];
    wire       byte_large = eff_byte[`OBC_PKG_BIT];
    wire [PADS-1:0] bonded_mask = byte_large ? BONDED_LARGE[PADS-1:0] : BONDED_SMALL[PADS-1:0]; // RQ1

    // Programming tool read; outside programming mode nothing answers.
    always @(posedge aclk) begin
        if (!aresetn) begin
            prog_rdata_ff  <= `OBC_ERASED_BYTE;
            prog_rvalid_ff <= 1'b0;
        end else begin
            prog_rvalid_ff <= prog_mode & prog_rd; // RQ13
            if (prog_mode && prog_rd) begin
                prog_rdata_ff <= eff_byte; // RQ13
            end
        end
    end

    // ------------------------------------------------------------------------
    // Configuration latch
    // ------------------------------------------------------------------------

    // Fields load only while reset is held, so the clock source never moves at run time.
    always @(posedge aclk) begin
        if (!aresetn) begin
            package_select_bit_ff <= byte_large; // RQ14 RQ1
            clock_source_type_ff  <= byte_type; // RQ7
            reset_delay_select_ff <= eff_byte[`OBC_RSTDLY_BIT]; // RQ4
            pll_x2_en_ff          <= ~eff_byte[`OBC_PLLOFF_BIT]; // RQ10
            if (byte_type == `OBC_SRC_RESONATOR) begin
                osc_current_sel_ff <= byte_range; // RQ8
                op_freq_range_ff   <= byte_range;
            end else begin
                osc_current_sel_ff <= `OBC_RANGE_1_2;
                op_freq_range_ff   <= byte_range; // RQ9
            end
        end
    end

    // One select line per clock source type.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_src
            always @(posedge aclk) begin
                if (!aresetn) begin
                    source_onehot_ff[gi] <= ({30'h00000000, byte_type} == gi); // RQ7
                end
            end
        end
    endgenerate

    // Configurer mistakes, reported to software only.
    wire pll_bad_src   = pll_x2_en_ff & (clock_source_type_ff == `OBC_SRC_INT_RC); // RQ11
    wire pll_bad_range = pll_x2_en_ff & (op_freq_range_ff != `OBC_RANGE_2_4); // RQ12
    wire short_on_xtal = reset_delay_select_ff & (clock_source_type_ff == `OBC_SRC_RESONATOR); // RQ5

    // ------------------------------------------------------------------------
    // Reset and halt exit delay
    // ------------------------------------------------------------------------

    reg  [12:0] dly_cnt_ff;
    reg         halt_ff;
    reg         dly_active_ff;
    reg         halt_req;
    wire [12:0] dly_load = reset_delay_select_ff ? SHORT_DLY_CYC[12:0] : LONG_DLY_CYC[12:0]; // RQ4
    // With clock security on, the backup oscillator clocks the count at once.
    wire        count_ok = main_osc_ready | ~clock_security_function_n; // RQ6

    // The counter is loaded at reset and again when a wake event ends halt.
    always @(posedge aclk) begin
        if (!aresetn) begin
            dly_cnt_ff     <= 13'h0000;
            dly_active_ff  <= 1'b1;
            halt_ff        <= 1'b0;
            cpu_reset_n_ff <= 1'b0;
            cpu_hold_ff    <= 1'b1;
        end else begin
            if (dly_active_ff) begin
                if (count_ok) begin // RQ6
                    if (dly_cnt_ff == dly_load - 13'h0001) begin
                        dly_active_ff  <= 1'b0;
                        cpu_reset_n_ff <= 1'b1;
                        cpu_hold_ff    <= 1'b0;
                    end else begin
                        dly_cnt_ff <= dly_cnt_ff + 13'h0001; // RQ4
                    end
                end
            end else if (halt_ff) begin
                if (wake_event) begin
                    halt_ff       <= 1'b0;
                    dly_active_ff <= 1'b1; // RQ4
                    dly_cnt_ff    <= 13'h0000;
                end
            end else if (halt_req) begin
                halt_ff     <= 1'b1;
                cpu_hold_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------------

    reg        aw_got_ff;
    reg        w_got_ff;
    reg [4:0]  aw_addr_ff;
    reg [31:0] w_data_ff;
    reg [3:0]  w_strb_ff;
    wire       do_write = aw_got_ff & w_got_ff & ~s_axi_bvalid_ff;
    wire       wr_dir   = do_write & (aw_addr_ff == {1'b0, `OBC_ADDR_PAD_DIR});
    wire       wr_pu    = do_write & (aw_addr_ff == `OBC_ADDR_PAD_PU);
    wire       wr_ctrl  = do_write & (aw_addr_ff == {1'b0, `OBC_ADDR_CTRL});
    wire       wr_ok    = wr_dir | wr_pu | wr_ctrl | (aw_addr_ff == {1'b0, `OBC_ADDR_STATUS})
                          | (aw_addr_ff == {1'b0, `OBC_ADDR_CONFIG});

    // Address and data are taken independently; ready is raised for one cycle.
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff        <= 1'b0;
            w_got_ff         <= 1'b0;
            aw_addr_ff       <= 5'h00;
            w_data_ff        <= 32'h00000000;
            w_strb_ff        <= 4'h0;
            s_axi_awready_ff <= 1'b0;
            s_axi_wready_ff  <= 1'b0;
            s_axi_bvalid_ff  <= 1'b0;
            s_axi_bresp_ff   <= `OBC_RESP_OKAY;
        end else begin
            s_axi_awready_ff <= s_axi_awvalid & ~s_axi_awready_ff & ~aw_got_ff;
            s_axi_wready_ff  <= s_axi_wvalid & ~s_axi_wready_ff & ~w_got_ff;
            if (s_axi_awvalid && s_axi_awready_ff) begin
                aw_got_ff  <= 1'b1;
                aw_addr_ff <= {s_axi_awaddr[4:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready_ff) begin
                w_got_ff  <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got_ff       <= 1'b0;
                w_got_ff        <= 1'b0;
                s_axi_bvalid_ff <= 1'b1;
                s_axi_bresp_ff  <= wr_ok ? `OBC_RESP_OKAY : `OBC_RESP_SLVERR;
            end else if (s_axi_bvalid_ff && s_axi_bready) begin
                s_axi_bvalid_ff <= 1'b0;
            end
        end
    end

    // Writing one to control bit 0 requests halt.
    always @* begin
        halt_req = wr_ctrl & w_strb_ff[0] & w_data_ff[0];
    end

    // Pad registers; during reset unbonded pads become pulled-up inputs.
    integer bi;
    always @(posedge aclk) begin
        if (!aresetn) begin
            pad_dir_ff    <= `OBC_PAD_DIR_RST; // RQ2
            pad_pullup_ff <= ~bonded_mask; // RQ2
        end else begin
            for (bi = 0; bi < PADS; bi = bi + 1) begin
                if (wr_dir && w_strb_ff[bi/8]) begin
                    pad_dir_ff[bi] <= w_data_ff[bi];
                end
                if (wr_pu && w_strb_ff[bi/8]) begin
                    pad_pullup_ff[bi] <= w_data_ff[bi];
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------------

    reg [31:0] rd_mux;
    reg        rd_ok;
    reg [31:0] dir_word;
    reg [31:0] pu_word;

    // Read data selection by word address.
    always @* begin
        dir_word = 32'h00000000;
        pu_word  = 32'h00000000;
        dir_word[PADS-1:0] = pad_dir_ff;
        pu_word[PADS-1:0]  = pad_pullup_ff;
        rd_ok  = 1'b1;
        rd_mux = 32'h00000000;
        case ({s_axi_araddr[4:2], 2'h0})
            {1'b0, `OBC_ADDR_CTRL}:    rd_mux = {31'h00000000, halt_ff};
            {1'b0, `OBC_ADDR_STATUS}:  rd_mux = {27'h0000000, count_ok, dly_active_ff, halt_ff,
                                                 cpu_hold_ff, cpu_reset_n_ff};
            {1'b0, `OBC_ADDR_CONFIG}:  rd_mux = {14'h0000, short_on_xtal, pll_bad_range, pll_bad_src,
                                                 source_onehot_ff, osc_current_sel_ff, op_freq_range_ff,
                                                 pll_x2_en_ff, reset_delay_select_ff,
                                                 clock_source_type_ff, package_select_bit_ff};
            {1'b0, `OBC_ADDR_PAD_DIR}: rd_mux = dir_word;
            `OBC_ADDR_PAD_PU:          rd_mux = pu_word;
            default:                   rd_ok  = 1'b0;
        endcase
    end

    // Read address is taken one cycle after arvalid; data follow on the same edge.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready_ff <= 1'b0;
            s_axi_rvalid_ff  <= 1'b0;
            s_axi_rdata_ff   <= 32'h00000000;
            s_axi_rresp_ff   <= `OBC_RESP_OKAY;
        end else begin
            s_axi_arready_ff <= s_axi_arvalid & ~s_axi_arready_ff & ~s_axi_rvalid_ff;
            if (s_axi_arvalid && s_axi_arready_ff) begin
                s_axi_rvalid_ff <= 1'b1;
                s_axi_rdata_ff  <= rd_mux;
                s_axi_rresp_ff  <= rd_ok ? `OBC_RESP_OKAY : `OBC_RESP_SLVERR;
            end else if (s_axi_rvalid_ff && s_axi_rready) begin
                s_axi_rvalid_ff <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// >>> obc_option_config_asserts.sv
// Checker for the option byte decoder: latched fields, reset delay, pads and programming reads.
// Assumes it is bound to obc_option_config and sees only that module's ports.
`default_nettype none

module obc_option_config_asserts #(
    parameter integer NUM_PORTS     = 4,
    parameter integer LONG_DLY_CYC  = 4096,
    parameter integer SHORT_DLY_CYC = 256,
    parameter [31:0]  BONDED_LARGE  = 32'hFFFFFFFF,
    parameter [31:0]  BONDED_SMALL  = 32'h00FFFFFF
) (
    // Clock, reset and option byte inputs.
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire logic [7:0]             opt_byte_nv,
    input wire logic                   opt_byte_erased,
    input wire logic                   clock_security_function_n,
    input wire logic                   main_osc_ready,
    input wire logic                   prog_mode,
    input wire logic                   prog_rd,
    // Decoded outputs.
    input wire logic [7:0]             prog_rdata_ff,
    input wire logic                   prog_rvalid_ff,
    input wire logic                   package_select_bit_ff,
    input wire logic [1:0]             clock_source_type_ff,
    input wire logic [3:0]             source_onehot_ff,
    input wire logic [2:0]             osc_current_sel_ff,
    input wire logic [2:0]             op_freq_range_ff,
    input wire logic                   pll_x2_en_ff,
    input wire logic                   reset_delay_select_ff,
    input wire logic                   cpu_reset_n_ff,
    input wire logic [NUM_PORTS*8-1:0] pad_dir_ff,
    input wire logic [NUM_PORTS*8-1:0] pad_pullup_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Helper logic
    // ----
    logic [7:0]             eff;
    logic [7:0]             prev_ff;
    logic [15:0]            cnt_ff;
    logic [15:0]            nxt_cnt;
    logic [NUM_PORTS*8-1:0] unb;
    int                     dly;
    // Effective byte, delay length and unbonded pad mask.
    assign eff = opt_byte_erased ? 8'hFF : opt_byte_nv;
    assign dly = reset_delay_select_ff ? SHORT_DLY_CYC : LONG_DLY_CYC;
    assign unb = ~(package_select_bit_ff ? BONDED_LARGE[NUM_PORTS*8-1:0] : BONDED_SMALL[NUM_PORTS*8-1:0]);
    // The delay counter may only advance on the main oscillator or with security on.
    assign nxt_cnt = cnt_ff + {15'h0, !cpu_reset_n_ff && (main_osc_ready || !clock_security_function_n)};
    // Keeps last cycle's byte and the number of edges that could count.
    always_ff @(posedge aclk) begin
        prev_ff <= eff;
        cnt_ff <= aresetn ? nxt_cnt : 16'h0;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_release; $rose(aresetn); endsequence
    sequence s_prog_req; prog_mode && prog_rd; endsequence
    // ----
    // Properties
    // ----
    property p_pkg; s_release |-> package_select_bit_ff == prev_ff[7]; endproperty
    property p_type;
        s_release |-> clock_source_type_ff == prev_ff[5:4] && source_onehot_ff == (4'h1 << prev_ff[5:4]);
    endproperty
    property p_range;
        s_release |-> op_freq_range_ff == prev_ff[3:1] && osc_current_sel_ff == (prev_ff[5:4] == 2'h0 ? prev_ff[3:1] : 3'h0);
    endproperty
    property p_pll; s_release |-> pll_x2_en_ff == !prev_ff[0] && reset_delay_select_ff == prev_ff[6]; endproperty
    property p_pad; s_release |-> pad_dir_ff == '0 && pad_pullup_ff == unb; endproperty
    property p_dly; $rose(cpu_reset_n_ff) |-> cnt_ff >= dly && cnt_ff <= dly + 2; endproperty
    property p_hold;
        aresetn && $past(aresetn) |-> $stable({package_select_bit_ff, clock_source_type_ff, source_onehot_ff,
            osc_current_sel_ff, op_freq_range_ff, pll_x2_en_ff, reset_delay_select_ff});
    endproperty
    property p_prog; s_prog_req |=> prog_rvalid_ff && prog_rdata_ff == prev_ff; endproperty
    a_pkg: assert property (p_pkg) else $error("package bit not latched from the byte");
    a_type: assert property (p_type) else $error("clock source type decode wrong");
    a_range: assert property (p_range) else $error("range field decode wrong");
    a_pll: assert property (p_pll) else $error("multiplier or delay bit decode wrong");
    a_pad: assert property (p_pad) else $error("unbonded pads not pulled-up inputs");
    a_dly: assert property (p_dly) else $error("reset delay length wrong");
    a_hold: assert property (p_hold) else $error("decoded fields changed while running");
    a_prog: assert property (p_prog) else $error("programming read wrong");
endmodule

bind obc_option_config obc_option_config_asserts #(.NUM_PORTS(NUM_PORTS), .LONG_DLY_CYC(LONG_DLY_CYC),
    .SHORT_DLY_CYC(SHORT_DLY_CYC), .BONDED_LARGE(BONDED_LARGE), .BONDED_SMALL(BONDED_SMALL)) u_asserts (
    .aclk, .aresetn, .opt_byte_nv, .opt_byte_erased, .clock_security_function_n, .main_osc_ready,
    .prog_mode, .prog_rd, .prog_rdata_ff, .prog_rvalid_ff, .package_select_bit_ff, .clock_source_type_ff,
    .source_onehot_ff, .osc_current_sel_ff, .op_freq_range_ff, .pll_x2_en_ff, .reset_delay_select_ff,
    .cpu_reset_n_ff, .pad_dir_ff, .pad_pullup_ff);
`default_nettype wire

// >>> test_option_byte_clock_reset_config.sv
// Self-checking bench: random option bytes through reset, AXI4-Lite reads, halt and wake.
// Assumes the decoder is built with short delay counts and the default bonded masks.
`include "obc_consts.vh"
`default_nettype none

module test_option_byte_clock_reset_config;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LONG = 16;
    localparam int SHORT = 4;
    localparam int WAIT = 6;
    // ----
    // Signals
    // ----
    logic        aclk = 1'b0, aresetn = 1'b0, opt_byte_erased = 1'b0, clock_security_function_n = 1'b1;
    logic        main_osc_ready = 1'b0, prog_mode = 1'b0, prog_rd = 1'b0, wake_event = 1'b0;
    logic [7:0]  opt_byte_nv = 8'hFF, prog_rdata_ff, b, eb;
    logic        prog_rvalid_ff, package_select_bit_ff, pll_x2_en_ff, reset_delay_select_ff, cpu_reset_n_ff;
    logic        cpu_hold_ff, era, clock_security_function;
    logic [1:0]  clock_source_type_ff, s_axi_bresp_ff, s_axi_rresp_ff, r;
    logic [3:0]  source_onehot_ff, s_axi_wstrb = 4'hF;
    logic [2:0]  osc_current_sel_ff, op_freq_range_ff;
    logic [31:0] pad_dir_ff, pad_pullup_ff, s_axi_wdata = 32'h0, s_axi_rdata_ff, d, v;
    logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready_ff, s_axi_wready_ff, s_axi_bvalid_ff;
    logic        s_axi_arready_ff, s_axi_rvalid_ff;
    int          errors = 0, tests_run = 0, i, n, w, cyc;

    obc_option_config #(.LONG_DLY_CYC(LONG), .SHORT_DLY_CYC(SHORT)) u_dut (
        .aclk, .aresetn, .opt_byte_nv, .opt_byte_erased, .clock_security_function_n, .main_osc_ready,
        .prog_mode, .prog_rd, .prog_rdata_ff, .prog_rvalid_ff, .wake_event, .package_select_bit_ff,
        .clock_source_type_ff, .source_onehot_ff, .osc_current_sel_ff, .op_freq_range_ff, .pll_x2_en_ff,
        .reset_delay_select_ff, .cpu_reset_n_ff, .cpu_hold_ff, .pad_dir_ff, .pad_pullup_ff,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready_ff, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready_ff, .s_axi_bresp_ff, .s_axi_bvalid_ff, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready_ff, .s_axi_rdata_ff, .s_axi_rresp_ff, .s_axi_rvalid_ff, .s_axi_rready);

    // Free-running CPU clock at 250 MHz.
    always #2 aclk = ~aclk;

    // ----
    // Tasks and functions
    // ----
    // Compares one value and counts the comparison.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One AXI4-Lite write; address and data are offered together.
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] dt, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= dt;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int k = 0; k < 60 && (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid_ff); k++) begin
            @(posedge aclk);
            if (s_axi_awready_ff) s_axi_awvalid <= 1'b0;
            if (s_axi_wready_ff) s_axi_wvalid <= 1'b0;
        end
        rs = s_axi_bresp_ff;
        s_axi_bready <= 1'b0;
    endtask
    // One AXI4-Lite read.
    task automatic axi_rd(input logic [4:0] a, output logic [31:0] dt, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int k = 0; k < 60 && !s_axi_rvalid_ff; k++) begin
            @(posedge aclk);
            if (s_axi_arready_ff) s_axi_arvalid <= 1'b0;
        end
        dt = s_axi_rdata_ff;
        rs = s_axi_rresp_ff;
        s_axi_rready <= 1'b0;
    endtask
    // Counts edges until reset or hold ends; the main oscillator settles after WAIT edges.
    task automatic wait_cyc(input logic for_hold, output int c);
        c = 0;
        do begin
            @(posedge aclk);
            c++;
            if (c == WAIT) main_osc_ready <= 1'b1;
        end while ((for_hold ? cpu_hold_ff : !cpu_reset_n_ff) && c < 5000);
    endtask
    // Expected CONFIG word for a given option byte.
    function automatic logic [31:0] exp_cfg(input logic [7:0] o);
        logic pe;
        pe = !o[0];
        exp_cfg = {14'h0, o[6] && o[5:4] == 2'h0, pe && o[3:1] != 3'h1, pe && o[5:4] == 2'h2,
                   4'h1 << o[5:4], o[5:4] == 2'h0 ? o[3:1] : 3'h0, o[3:1], pe, o[6], o[5:4], o[7]};
    endfunction
    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ----
    // Main sequence: every clock type, erased and random bytes, both security settings.
    // ----
    initial begin
        void'($urandom(32'hDC867DE6));
        for (i = 0; i < 8; i++) begin
            b = $urandom;
            b[5:4] = i[1:0];
            if (b[5:4] == 2'h0) b[6] = 1'b0;
            if (b[5:4] == 2'h2) b[0] = 1'b1;
            if (!b[0]) b[3:1] = 3'h1;
            era = (i == 0);
            clock_security_function = $urandom_range(1, 0);
            eb = era ? 8'hFF : b;
            @(posedge aclk);
            aresetn <= 1'b0;
            main_osc_ready <= 1'b0;
            opt_byte_nv <= b;
            opt_byte_erased <= era;
            clock_security_function_n <= clock_security_function;
            repeat (2) @(posedge aclk);
            aresetn <= 1'b1;
            wait_cyc(1'b0, cyc);
            n = eb[6] ? SHORT : LONG;
            w = clock_security_function ? WAIT : 0;
            check({31'h0, cyc >= n + w + 1 && cyc <= n + w + 4}, 32'h1);
            check(pad_pullup_ff, eb[7] ? 32'h0 : 32'hFF000000);
            check(pad_dir_ff, 32'h0);
            prog_mode <= i[0];
            prog_rd <= 1'b1;
            @(posedge aclk);
            prog_rd <= 1'b0;
            prog_mode <= 1'b0;
            @(posedge aclk);
            check({31'h0, prog_rvalid_ff}, {31'h0, i[0]});
            if (i[0]) check({24'h0, prog_rdata_ff}, {24'h0, eb});
            // The byte changes under a running device; decoded settings must not follow.
            opt_byte_nv <= ~b;
            opt_byte_erased <= 1'b0;
            axi_rd(`OBC_ADDR_CONFIG, d, r);
            check(d, exp_cfg(eb));
            axi_rd(5'h14, d, r);
            check({30'h0, r}, {30'h0, `OBC_RESP_SLVERR});
            axi_wr(5'h18, 32'h1, r);
            check({30'h0, r}, {30'h0, `OBC_RESP_SLVERR});
            v = $urandom;
            if (!eb[7]) v[31:24] = 8'h00;
            axi_wr(`OBC_ADDR_PAD_DIR, v, r);
            check({30'h0, r}, {30'h0, `OBC_RESP_OKAY});
            axi_rd(`OBC_ADDR_PAD_DIR, d, r);
            check(d, v);
            axi_wr(`OBC_ADDR_CTRL, 32'h1, r);
            axi_rd(`OBC_ADDR_STATUS, d, r);
            check({30'h0, d[2:1]}, 32'h3);
            wake_event <= 1'b1;
            @(posedge aclk);
            wake_event <= 1'b0;
            wait_cyc(1'b1, cyc);
            check({31'h0, cyc >= n - 1 && cyc <= n + 4}, 32'h1);
            $display("test %0d done errors=%0d", i, errors);
        end
        complete_run();
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        #40000;
        errors++;
        complete_run();
    end
endmodule
`default_nettype wire
